// ### hw/tcr_regs.sv
// Control register bank with host watchdog, Avalon-MM slave
`timescale 1ns/1ps
module tcr_regs #(
  parameter int STEP_CYC = tcr_pkg::WD_STEP_CYC
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic [2:0] avs_address,
  input  wire logic       avs_read,
  input  wire logic       avs_write,
  input  wire logic [7:0] avs_writedata,
  output logic      [7:0] avs_readdata,
  output logic            avs_waitrequest,
  input  wire logic [6:0] analog_status,
  input  wire logic       tx_active,
  output logic            watchdog_event,
  output logic            high_rail_regulator_on,
  output logic            second_converter_on,
  output logic            clock_out_on,
  output logic      [2:0] high_rail_current_trim,
  output logic      [6:0] monitor_ctrl,
  output logic            activity_pin_o,
  output logic            activity_pin_oe
);
  logic [7:0]  wdog_reg;
  logic [7:0]  pwr_reg;
  logic [7:0]  ana1_reg;
  logic [31:0] step_cnt_reg;
  logic [3:0]  steps_left_reg;
  logic        done_reg;

  // Answer one cycle after request: waitrequest low while done_reg high
  wire req      = (avs_read | avs_write) & ~done_reg;
  // Write lands on the answer edge, the one at which the master sees waitrequest low
  wire wr_fire  = ce & avs_write & done_reg;
  wire wr_wdog  = wr_fire & (avs_address == tcr_pkg::ADDR_WDOG);
  wire wr_pwr   = wr_fire & (avs_address == tcr_pkg::ADDR_PWR);
  wire wr_ana1  = wr_fire & (avs_address == tcr_pkg::ADDR_ANA1);
  wire reload   = wr_wdog & avs_writedata[tcr_pkg::WD_ARM_BIT];
  wire armed    = wdog_reg[tcr_pkg::WD_ARM_BIT];
  wire step_end = step_cnt_reg == STEP_CYC - 1;
  wire expire   = armed & ~reload & step_end & (steps_left_reg == 4'h0);

  logic [7:0] rd_mux;
  always_comb begin
    case (avs_address)
      tcr_pkg::ADDR_WDOG:  rd_mux = wdog_reg & tcr_pkg::WDOG_MASK;
      tcr_pkg::ADDR_PWR:   rd_mux = pwr_reg & tcr_pkg::PWR_MASK;
      tcr_pkg::ADDR_ANA1:  rd_mux = ana1_reg;
      tcr_pkg::ADDR_ASTAT: rd_mux = {1'b0, analog_status};
      tcr_pkg::ADDR_REV:   rd_mux = tcr_pkg::REV_ID;
      default:             rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      done_reg        <= 1'b0;
      avs_readdata    <= 8'h00;
    end else if (ce) begin
      done_reg        <= req;
      avs_waitrequest <= ~req;
      if (req) begin
        avs_readdata <= avs_read ? rd_mux : 8'h00;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wdog_reg <= tcr_pkg::WDOG_RESET;
      pwr_reg  <= tcr_pkg::PWR_RESET;
      ana1_reg <= tcr_pkg::ANA1_RESET;
    end else if (ce) begin
      if (wr_wdog) begin
        wdog_reg <= avs_writedata & tcr_pkg::WDOG_MASK;
      end
      if (wr_pwr) begin
        pwr_reg <= avs_writedata & tcr_pkg::PWR_MASK;
      end
      if (wr_ana1) begin
        ana1_reg <= avs_writedata & tcr_pkg::ANA1_MASK;
      end
    end
  end

  // Countdown in steps of about 32.8 ms; code n gives n+1 steps
  always_ff @(posedge mclk) begin
    if (rst) begin
      step_cnt_reg   <= 32'h0;
      steps_left_reg <= 4'hf;
      watchdog_event <= 1'b0;
    end else if (ce) begin
      watchdog_event <= expire;
      if (reload) begin
        step_cnt_reg   <= 32'h0;
        steps_left_reg <= avs_writedata[3:0];
      end else if (!armed) begin
        step_cnt_reg   <= 32'h0;
        steps_left_reg <= wdog_reg[3:0];
      end else if (step_end) begin
        step_cnt_reg   <= 32'h0;
        // After expiry the period restarts so the event repeats
        steps_left_reg <= (steps_left_reg == 4'h0) ? wdog_reg[3:0] : steps_left_reg - 4'h1;
      end else begin
        step_cnt_reg <= step_cnt_reg + 32'h1;
      end
    end
  end

  // Independent cycle count since the last reload or period end, held at zero while disarmed, read only by the period checks
  logic [31:0] ref_cyc_reg;
  wire  [31:0] ref_period = 32'((32'(wdog_reg[3:0]) + 32'h1) * 32'(STEP_CYC));
  wire         ref_end    = ref_cyc_reg == ref_period - 32'h1;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ref_cyc_reg <= 32'h0;
    end else if (ce) begin
      if (reload || !armed || ref_end) begin
        ref_cyc_reg <= 32'h0;
      end else begin
        ref_cyc_reg <= ref_cyc_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      high_rail_regulator_on <= tcr_pkg::PWR_RESET[tcr_pkg::PWR_HR_BIT];
      second_converter_on    <= tcr_pkg::PWR_RESET[tcr_pkg::PWR_SC_BIT];
      clock_out_on           <= tcr_pkg::PWR_RESET[tcr_pkg::PWR_CK_BIT];
      high_rail_current_trim <= tcr_pkg::PWR_RESET[2:0];
      monitor_ctrl           <= tcr_pkg::ANA1_RESET[7:1];
      activity_pin_o         <= 1'b0;
      activity_pin_oe        <= 1'b0;
    end else if (ce) begin
      high_rail_regulator_on <= pwr_reg[tcr_pkg::PWR_HR_BIT];
      second_converter_on    <= pwr_reg[tcr_pkg::PWR_SC_BIT];
      clock_out_on           <= pwr_reg[tcr_pkg::PWR_CK_BIT];
      high_rail_current_trim <= pwr_reg[2:0];
      monitor_ctrl           <= ana1_reg[7:1];
      activity_pin_o         <= tx_active & pwr_reg[tcr_pkg::PWR_ACT_BIT];
      activity_pin_oe        <= pwr_reg[tcr_pkg::PWR_ACT_BIT];
    end
  end

  property p_unmapped_zero;
    @(posedge mclk) disable iff (rst)
      (ce && req && avs_read && avs_address == 3'h4) |=> (avs_readdata == 8'h00 && !avs_waitrequest);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("Address 4 not zero");

  property p_wdog_reserved;
    @(posedge mclk) disable iff (rst) (wdog_reg[6:4] == 3'h0);
  endproperty
  a_wdog_reserved: assert property (p_wdog_reserved) else $error("Watchdog reserved bits set");

  property p_pwr_reserved;
    @(posedge mclk) disable iff (rst) (pwr_reg[7] == 1'b0);
  endproperty
  a_pwr_reserved: assert property (p_pwr_reserved) else $error("Power reserved bit set");

  property p_reload;
    @(posedge mclk) disable iff (rst)
      (ce && reload) |=> (step_cnt_reg == 32'h0 && steps_left_reg == $past(avs_writedata[3:0]));
  endproperty
  a_reload: assert property (p_reload) else $error("Arm write did not reload");

  property p_no_event_disarmed;
    @(posedge mclk) disable iff (rst) (ce && !armed) |=> !watchdog_event;
  endproperty
  a_no_event_disarmed: assert property (p_no_event_disarmed) else $error("Event while disarmed");

  property p_event_cause;
    @(posedge mclk) disable iff (rst)
      (ce && armed && !reload && step_end && steps_left_reg == 4'h0) |=> watchdog_event;
  endproperty
  a_event_cause: assert property (p_event_cause) else $error("Missed watchdog event");

  property p_pin_tristate;
    @(posedge mclk) disable iff (rst)
      (ce && !pwr_reg[tcr_pkg::PWR_ACT_BIT]) |=> !activity_pin_oe;
  endproperty
  a_pin_tristate: assert property (p_pin_tristate) else $error("Activity pin driven while off");

  property p_pin_mirror;
    @(posedge mclk) disable iff (rst)
      (ce && pwr_reg[tcr_pkg::PWR_ACT_BIT]) |=> (activity_pin_oe && activity_pin_o == $past(tx_active));
  endproperty
  a_pin_mirror: assert property (p_pin_mirror) else $error("Activity pin not mirroring");

  property p_outputs_follow;
    @(posedge mclk) disable iff (rst)
      ce |=> (high_rail_regulator_on == $past(pwr_reg[6]) && second_converter_on == $past(pwr_reg[5])
              && clock_out_on == $past(pwr_reg[4]) && high_rail_current_trim == $past(pwr_reg[2:0]));
  endproperty
  a_outputs_follow: assert property (p_outputs_follow) else $error("Power outputs wrong");

  property p_write_pwr;
    @(posedge mclk) disable iff (rst) (wr_pwr) |=> (pwr_reg == ($past(avs_writedata) & 8'h7f));
  endproperty
  a_write_pwr: assert property (p_write_pwr) else $error("Power write lost");

  property p_write_wdog;
    @(posedge mclk) disable iff (rst)
      wr_wdog |=> (wdog_reg == ($past(avs_writedata) & tcr_pkg::WDOG_MASK));
  endproperty
  a_write_wdog: assert property (p_write_wdog) else $error("Watchdog write lost");

  sequence s_request_taken;
    ce && req;
  endsequence

  sequence s_answer_cycle;
    !avs_waitrequest ##1 (avs_waitrequest || !$past(ce));
  endsequence

  property p_answer;
    @(posedge mclk) disable iff (rst)
      s_request_taken |=> s_answer_cycle;
  endproperty
  a_answer: assert property (p_answer) else $error("Answer not one cycle");

  property p_commit_on_answer;
    @(posedge mclk) disable iff (rst)
      wr_fire |-> !avs_waitrequest;
  endproperty
  a_commit_on_answer: assert property (p_commit_on_answer) else $error("Write outside answer");

  property p_wait_single;
    @(posedge mclk) disable iff (rst)
      (ce && !avs_waitrequest) |=> avs_waitrequest;
  endproperty
  a_wait_single: assert property (p_wait_single) else $error("Answer held too long");

  property p_read_wdog;
    @(posedge mclk) disable iff (rst)
      (ce && req && avs_read && avs_address == tcr_pkg::ADDR_WDOG) |=>
        (avs_readdata[6:4] == 3'h0 && avs_readdata[7] == $past(armed));
  endproperty
  a_read_wdog: assert property (p_read_wdog) else $error("Watchdog read wrong");

  property p_read_pwr;
    @(posedge mclk) disable iff (rst)
      (ce && req && avs_read && avs_address == tcr_pkg::ADDR_PWR) |=>
        (avs_readdata == {1'b0, $past(pwr_reg[6:0])});
  endproperty
  a_read_pwr: assert property (p_read_pwr) else $error("Power read wrong");

  property p_read_status;
    @(posedge mclk) disable iff (rst)
      (ce && req && avs_read && avs_address == tcr_pkg::ADDR_ASTAT) |=>
        (avs_readdata == {1'b0, $past(analog_status)});
  endproperty
  a_read_status: assert property (p_read_status) else $error("Status read wrong");

  property p_read_rev;
    @(posedge mclk) disable iff (rst)
      (ce && req && avs_read && avs_address == tcr_pkg::ADDR_REV) |=> (avs_readdata == tcr_pkg::REV_ID);
  endproperty
  a_read_rev: assert property (p_read_rev) else $error("Revision read wrong");

  property p_read_high;
    @(posedge mclk) disable iff (rst)
      (ce && req && avs_read && avs_address[2:1] == 2'b11) |=> (avs_readdata == 8'h00);
  endproperty
  a_read_high: assert property (p_read_high) else $error("Unused address not zero");

  property p_read_ana1;
    @(posedge mclk) disable iff (rst)
      (ce && req && avs_read && avs_address == tcr_pkg::ADDR_ANA1) |=>
        (avs_readdata[7] == 1'b0 && avs_readdata[0] == 1'b0);
  endproperty
  a_read_ana1: assert property (p_read_ana1) else $error("Reserved bits read set");

  property p_write_ignored;
    @(posedge mclk) disable iff (rst)
      (wr_fire && avs_address >= tcr_pkg::ADDR_ASTAT) |=>
        ($stable(wdog_reg) && $stable(pwr_reg) && $stable(ana1_reg));
  endproperty
  a_write_ignored: assert property (p_write_ignored) else $error("Read-only write landed");

  // Reset outranks the enable, so this holds whatever ce does
  property p_reset_values;
    @(posedge mclk)
      rst |=> (wdog_reg == tcr_pkg::WDOG_RESET && pwr_reg == tcr_pkg::PWR_RESET && avs_waitrequest
               && !watchdog_event && !activity_pin_oe);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("Reset values wrong");

  property p_freeze;
    @(posedge mclk) disable iff (rst)
      (!rst && !ce) |=> ($stable(wdog_reg) && $stable(pwr_reg) && $stable(step_cnt_reg)
                         && $stable(steps_left_reg) && $stable(avs_waitrequest) && $stable(watchdog_event));
  endproperty
  a_freeze: assert property (p_freeze) else $error("State moved while disabled");

  property p_disarmed_idle;
    @(posedge mclk) disable iff (rst)
      (ce && !armed && !reload) |=> (step_cnt_reg == 32'h0 && steps_left_reg == $past(wdog_reg[3:0]));
  endproperty
  a_disarmed_idle: assert property (p_disarmed_idle) else $error("Countdown ran while disarmed");

  property p_period_event;
    @(posedge mclk) disable iff (rst)
      (ce && armed && !reload && ref_end) |=> watchdog_event;
  endproperty
  a_period_event: assert property (p_period_event) else $error("Event missing at period end");

  property p_event_only_at_end;
    @(posedge mclk) disable iff (rst)
      (ce && !(armed && !reload && ref_end)) |=> !watchdog_event;
  endproperty
  a_event_only_at_end: assert property (p_event_only_at_end) else $error("Event before period end");

  property p_pin_low_when_off;
    @(posedge mclk) disable iff (rst)
      (ce && !pwr_reg[tcr_pkg::PWR_ACT_BIT]) |=> !activity_pin_o;
  endproperty
  a_pin_low_when_off: assert property (p_pin_low_when_off) else $error("Activity data while off");
endmodule // tcr_regs

// ### hw/tcr_pkg.sv
// Constants for the transceiver control register bank
package tcr_pkg;
  localparam logic [2:0] ADDR_WDOG    = 3'h0;
  localparam logic [2:0] ADDR_PWR     = 3'h1;
  localparam logic [2:0] ADDR_ANA1    = 3'h2;
  localparam logic [2:0] ADDR_ASTAT   = 3'h3;
  localparam logic [2:0] ADDR_REV     = 3'h5;
  localparam logic [7:0] WDOG_RESET   = 8'h0f;
  localparam logic [7:0] PWR_RESET    = 8'h74;
  localparam logic [7:0] ANA1_RESET   = 8'h60;
  localparam logic [7:0] WDOG_MASK    = 8'h8f;
  localparam logic [7:0] PWR_MASK     = 8'h7f;
  localparam logic [7:0] ANA1_MASK    = 8'h7e;
  localparam int         WD_ARM_BIT   = 7;
  localparam int         PWR_HR_BIT   = 6;
  localparam int         PWR_SC_BIT   = 5;
  localparam int         PWR_CK_BIT   = 4;
  localparam int         PWR_ACT_BIT  = 3;
  localparam int         CLK_HZ       = 50000000;
  localparam int         WD_STEP_US   = 32768;
  localparam int         WD_STEP_CYC  = (CLK_HZ / 1000) * WD_STEP_US / 1000;
  localparam logic [7:0] REV_ID       = 8'h2a;
endpackage

// ### bench/tcr_host.sv
// Avalon-MM host model for the register bank
`timescale 1ns/1ps
module tcr_host (
  input  wire logic       mclk,
  output logic      [2:0] avs_address,
  output logic            avs_read,
  output logic            avs_write,
  output logic      [7:0] avs_writedata,
  input  wire logic [7:0] avs_readdata,
  input  wire logic       avs_waitrequest
);
  initial begin
    avs_address = 3'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 8'h00;
  end
  // Idle edge first, so a release and a new request never share a time step
  task automatic xfer(input logic w, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
endmodule // tcr_host

// ### bench/test_tcr_regs.sv
// Self-checking bench for the control register bank
`timescale 1ns/1ps
module test_tcr_regs;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic       tx_active = 1'b0;
  logic [6:0] analog_status = 7'h5a;
  logic [2:0] adr;
  logic       ce = 1'b1;
  logic       rd, wr, wait_req, ev, hr, sc, ck, po, poe;
  logic [7:0] wd, rdat, q;
  logic [2:0] trim;
  int         n_mismatch = 0;
  int         checked = 0;
  int         n_ev = 0;
  int         n;
  always #10 mclk = ~mclk;
  always @(posedge mclk) if (ev === 1'b1) n_ev <= n_ev + 1;
  tcr_regs #(.STEP_CYC(8)) tcr_regs_inst (.mclk(mclk), .rst(rst), .ce(ce), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wait_req),
    .analog_status(analog_status), .tx_active(tx_active), .watchdog_event(ev), .high_rail_regulator_on(hr),
    .second_converter_on(sc), .clock_out_on(ck), .high_rail_current_trim(trim), .monitor_ctrl(),
    .activity_pin_o(po), .activity_pin_oe(poe));
  tcr_host tcr_host_inst (.mclk(mclk), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wait_req));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic w(input logic [2:0] a, input logic [7:0] d);
    tcr_host_inst.xfer(1'b1, a, d, q);
  endtask
  task automatic r(input logic [2:0] a, input logic [7:0] e);
    tcr_host_inst.xfer(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  task automatic stop_test;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic t_reset;
    r(3'h0, 8'h0f);
    r(3'h1, 8'h74);
    chk({1'b0, hr, sc, ck, trim, poe}, 8'h78);
    r(3'h4, 8'h00);
    r(3'h3, {1'b0, analog_status});
    r(3'h5, tcr_pkg::REV_ID);
    $display("test reset done");
  endtask
  task automatic t_power;
    w(3'h1, 8'hff);
    r(3'h1, 8'h7f);
    @(posedge mclk) tx_active <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({1'b0, hr, sc, ck, trim, poe}, 8'h7f);
    chk({7'h0, po}, 8'h01);
    w(3'h1, 8'h0b);
    repeat (2) @(posedge mclk);
    chk({1'b0, hr, sc, ck, trim, poe}, 8'h07);
    @(posedge mclk) tx_active <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({7'h0, po}, 8'h00);
    w(3'h1, 8'h00);
    repeat (2) @(posedge mclk);
    chk({7'h0, poe}, 8'h00);
    w(3'h4, 8'hff);
    r(3'h4, 8'h00);
    w(3'h3, 8'hff);
    r(3'h3, {1'b0, analog_status});
    w(3'h0, 8'h7f);
    r(3'h0, 8'h0f);
    $display("test power done");
  endtask
  // Refresh every three cycles, then let each period run out once
  task automatic t_wdog;
    for (int c = 0; c < 16; c++) begin
      w(3'h0, {4'h8, c[3:0]});
      n = n_ev;
      for (int k = 0; k < 3; k++) w(3'h0, {4'h8, c[3:0]});
      chk(8'(n_ev - n), 8'h00);
      n = 0;
      while (ev !== 1'b1 && n < 300) begin
        @(posedge mclk);
        n++;
      end
      chk(8'(n >= (c + 1) * 8 - 3 && n <= (c + 1) * 8 + 1), 8'h01);
    end
    r(3'h0, 8'h8f);
    w(3'h0, 8'h00);
    n = n_ev;
    repeat (300) @(posedge mclk);
    chk(8'(n_ev - n), 8'h00);
    $display("test watchdog done");
  endtask
  // Enable low freezes the countdown; a mid-run reset restores reset values
  task automatic t_freeze;
    w(3'h0, 8'h80);
    @(posedge mclk) ce <= 1'b0;
    n = n_ev;
    repeat (40) @(posedge mclk);
    chk(8'(n_ev - n), 8'h00);
    @(posedge mclk) ce <= 1'b1;
    n = 0;
    while (ev !== 1'b1 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    chk(8'(n >= 6 && n <= 9), 8'h01);
    w(3'h0, 8'h8f);
    w(3'h1, 8'h0b);
    @(posedge mclk) rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    r(3'h0, 8'h0f);
    r(3'h1, 8'h74);
    $display("test freeze done");
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_power();
    t_wdog();
    t_freeze();
    stop_test();
  end
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end
endmodule // test_tcr_regs
